// ---- rtl/uart_register_interface.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module uart_register_interface
  import uart_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire bus_req_t bus,
  output logic [31:0] rdata,
  // Serial line
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  // Interrupt
  output logic irq
);

  // ********************************************************
  // Reset release
  // ********************************************************
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ********************************************************
  // State
  // ********************************************************
  localparam state_t STATE_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1,
    rx_filt: 1'b1, line: 1'b1, rx_st: RX_IDLE, tx_st: TX_IDLE,
    default: '0};

  state_t s;
  state_t next_s;
  logic tick;
  logic tx_out;
  logic rx_in;
  logic [31:0] stat;
  logic irq_want;

  function automatic logic par_of(input logic [2:0] p,
                                  input logic [7:0] d);
    unique case (p)
      PAR_EVEN: par_of = ^d;
      PAR_ODD: par_of = ~^d;
      PAR_MARK: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  // Sixteen ticks per bit at the divided rate
  assign tick = (s.cd != 16'h0) && (s.div_cnt == s.cd - 16'h1);

  always_comb begin
    unique case (s.tx_st)
      TX_START: tx_out = 1'b0;
      TX_DATA: tx_out = s.tx_shift[0];
      TX_PAR: tx_out = s.tx_par;
      default: tx_out = 1'b1;
    endcase
  end

  // Receiver source per channel mode
  always_comb begin
    unique case (s.channel_mode)
      CHM_LOCAL: rx_in = tx_out;
      CHM_REMOTE: rx_in = 1'b1;
      default: rx_in = s.rx_filt;
    endcase
  end

  always_comb begin
    stat = 32'h0;
    stat[ST_RX_READY] = s.rx_ready && s.rx_en;
    stat[ST_TX_READY] = s.tx_en && !s.thr_full;
    stat[ST_OVERRUN] = s.overrun_flag;
    stat[ST_FRAMING] = s.framing_flag;
    stat[ST_PARITY] = s.parity_error_flag;
    stat[ST_TX_EMPTY] = s.tx_en && !s.thr_full
      && (s.tx_st == TX_IDLE);
  end
  assign irq_want = |(stat & s.mask);

  always_comb begin
    logic wr_ctrl;
    logic samp_rx;
    logic samp_tx;
    wr_ctrl = bus.wr && (bus.addr == OFF_CTRL);
    samp_rx = tick && (s.rx_tcnt == TICK_LAST);
    samp_tx = tick && (s.tx_tcnt == TICK_LAST);
    next_s = s;

    // ******************************************************
    // Input synchroniser
    // ******************************************************
    next_s.s1 = serial_rx_line;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.rx_filt = s.s3;
    end

    // ******************************************************
    // Baud divider
    // ******************************************************
    if (s.cd == 16'h0 || tick) begin
      next_s.div_cnt = 16'h0;
    end else begin
      next_s.div_cnt = s.div_cnt + 16'h1;
    end

    // Clears first so that hardware sets win
    if (wr_ctrl && bus.wdata[CMD_STATUS_RESET]) begin
      next_s.overrun_flag = 1'b0;
      next_s.framing_flag = 1'b0;
      next_s.parity_error_flag = 1'b0;
    end
    if (bus.rd && bus.addr == OFF_RHR) begin
      next_s.rx_ready = 1'b0;
    end

    // ******************************************************
    // Receiver
    // ******************************************************
    unique case (s.rx_st)
      RX_IDLE: begin
        if (s.rx_en && tick) begin
          if (!rx_in) begin
            next_s.low_cnt = s.low_cnt + 4'h1;
            if (s.low_cnt == START_MIN) begin
              next_s.rx_st = RX_DATA;
              next_s.rx_tcnt = 4'h0;
              next_s.rx_bcnt = 3'h0;
              next_s.rx_pe = 1'b0;
            end
          end else begin
            next_s.low_cnt = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_s.rx_tcnt = s.rx_tcnt + 4'h1;
        end
        if (samp_rx) begin
          next_s.rx_shift = {rx_in, s.rx_shift[7:1]};
          next_s.rx_bcnt = s.rx_bcnt + 3'h1;
          if (s.rx_bcnt == BIT_LAST) begin
            next_s.rx_st = (s.parity_type == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          next_s.rx_tcnt = s.rx_tcnt + 4'h1;
        end
        if (samp_rx) begin
          next_s.rx_pe = rx_in != par_of(s.parity_type, s.rx_shift);
          next_s.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_s.rx_tcnt = s.rx_tcnt + 4'h1;
        end
        if (samp_rx) begin
          next_s.rx_character = s.rx_shift;
          next_s.rx_ready = 1'b1;
          if (s.rx_ready) begin
            next_s.overrun_flag = 1'b1;
          end
          if (!rx_in) begin
            next_s.framing_flag = 1'b1;
          end
          if (s.rx_pe) begin
            next_s.parity_error_flag = 1'b1;
          end
          next_s.rx_st = RX_IDLE;
          next_s.low_cnt = 4'h0;
          if (s.rx_pend) begin
            next_s.rx_en = 1'b0;
            next_s.rx_pend = 1'b0;
          end
        end
      end
    endcase

    // ******************************************************
    // Transmitter
    // ******************************************************
    unique case (s.tx_st)
      TX_IDLE: begin
        if (s.tx_en && s.thr_full) begin
          next_s.tx_shift = s.tx_character;
          next_s.tx_par = par_of(s.parity_type, s.tx_character);
          next_s.thr_full = 1'b0;
          next_s.tx_st = TX_START;
          next_s.tx_tcnt = 4'h0;
        end else if (s.tx_pend) begin
          next_s.tx_en = 1'b0;
          next_s.tx_pend = 1'b0;
        end
      end
      TX_START: begin
        if (tick) begin
          next_s.tx_tcnt = s.tx_tcnt + 4'h1;
        end
        if (samp_tx) begin
          next_s.tx_st = TX_DATA;
          next_s.tx_bcnt = 3'h0;
        end
      end
      TX_DATA: begin
        if (tick) begin
          next_s.tx_tcnt = s.tx_tcnt + 4'h1;
        end
        if (samp_tx) begin
          next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
          next_s.tx_bcnt = s.tx_bcnt + 3'h1;
          if (s.tx_bcnt == BIT_LAST) begin
            next_s.tx_st = (s.parity_type == PAR_NONE) ? TX_STOP : TX_PAR;
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          next_s.tx_tcnt = s.tx_tcnt + 4'h1;
        end
        if (samp_tx) begin
          next_s.tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick) begin
          next_s.tx_tcnt = s.tx_tcnt + 4'h1;
        end
        if (samp_tx) begin
          next_s.tx_st = TX_IDLE;
        end
      end
    endcase

    // ******************************************************
    // Register writes
    // ******************************************************
    if (wr_ctrl) begin
      if (bus.wdata[CMD_RX_RESET]) begin
        next_s.rx_st = RX_IDLE;
        next_s.rx_en = 1'b0;
        next_s.rx_pend = 1'b0;
        next_s.low_cnt = 4'h0;
      end
      if (bus.wdata[CMD_TX_RESET]) begin
        next_s.tx_st = TX_IDLE;
        next_s.tx_en = 1'b0;
        next_s.tx_pend = 1'b0;
        next_s.thr_full = 1'b0;
      end
      if (bus.wdata[CMD_RX_ENABLE] && !bus.wdata[CMD_RX_DISABLE]) begin
        next_s.rx_en = 1'b1;
        next_s.rx_pend = 1'b0;
      end
      if (bus.wdata[CMD_RX_DISABLE]) begin
        if (next_s.rx_st == RX_IDLE) begin
          next_s.rx_en = 1'b0;
        end else begin
          next_s.rx_pend = 1'b1;
        end
      end
      if (bus.wdata[CMD_TX_ENABLE] && !bus.wdata[CMD_TX_DISABLE]) begin
        next_s.tx_en = 1'b1;
        next_s.tx_pend = 1'b0;
      end
      if (bus.wdata[CMD_TX_DISABLE]) begin
        if (next_s.tx_st == TX_IDLE && !next_s.thr_full) begin
          next_s.tx_en = 1'b0;
        end else begin
          next_s.tx_pend = 1'b1;
        end
      end
    end
    if (bus.wr) begin
      unique case (bus.addr)
        OFF_MODE: begin
          next_s.parity_type = bus.wdata[PAR_MSB:PAR_LSB];
          next_s.channel_mode = bus.wdata[CHM_MSB:CHM_LSB];
        end
        OFF_IER: next_s.mask = s.mask | (bus.wdata & STAT_VALID);
        OFF_IDR: next_s.mask = s.mask & ~bus.wdata;
        OFF_THR: begin
          next_s.tx_character = bus.wdata[7:0];
          next_s.thr_full = 1'b1;
        end
        OFF_BAUD: begin
          next_s.cd = bus.wdata[15:0];
          next_s.div_cnt = 16'h0;
        end
        default: begin
        end
      endcase
    end

    // ******************************************************
    // Read data, line and interrupt
    // ******************************************************
    next_s.rdata = 32'h0;
    if (bus.rd) begin
      unique case (bus.addr)
        OFF_MODE: begin
          next_s.rdata[PAR_MSB:PAR_LSB] = s.parity_type;
          next_s.rdata[CHM_MSB:CHM_LSB] = s.channel_mode;
        end
        OFF_IMR: next_s.rdata = s.mask;
        OFF_STAT: next_s.rdata = stat;
        OFF_RHR: next_s.rdata[7:0] = s.rx_character;
        OFF_BAUD: next_s.rdata[15:0] = s.cd;
        default: next_s.rdata = 32'h0;
      endcase
    end

    unique case (s.channel_mode)
      CHM_NORMAL: next_s.line = tx_out;
      CHM_LOCAL: next_s.line = 1'b1;
      default: next_s.line = s.rx_filt;
    endcase
    next_s.irq = |(stat & s.mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign serial_tx_line = s.line;
  assign irq = s.irq;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_rx_reset;
    bus.wr && bus.addr == OFF_CTRL && bus.wdata[CMD_RX_RESET]
      && !bus.wdata[CMD_RX_ENABLE] |=> !s.rx_en && s.rx_st == RX_IDLE;
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("receiver not reset");

  property p_tx_reset;
    bus.wr && bus.addr == OFF_CTRL && bus.wdata[CMD_TX_RESET]
      && !bus.wdata[CMD_TX_ENABLE] |=> !s.tx_en && !s.thr_full ##1 rst_n
      && serial_tx_line == 1'b1 || s.channel_mode != CHM_NORMAL;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("transmitter not reset");

  property p_rx_en_dis;
    bus.wr && bus.addr == OFF_CTRL && bus.wdata[CMD_RX_ENABLE]
      && bus.wdata[CMD_RX_DISABLE] && !s.rx_en |=> !s.rx_en;
  endproperty
  a_rx_en_dis: assert property (p_rx_en_dis)
    else $error("receiver enabled despite disable");

  property p_ovr_sticky;
    s.overrun_flag && !(bus.wr && bus.addr == OFF_CTRL
      && bus.wdata[CMD_STATUS_RESET]) |=> s.overrun_flag;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun flag dropped");

  property p_ier;
    bus.wr && bus.addr == OFF_IER |=>
      (s.mask & $past(bus.wdata) & STAT_VALID) == ($past(bus.wdata)
      & STAT_VALID);
  endproperty
  a_ier: assert property (p_ier)
    else $error("mask bit not set");

  property p_idr;
    bus.wr && bus.addr == OFF_IDR |=> (s.mask & $past(bus.wdata)) == 32'h0;
  endproperty
  a_idr: assert property (p_idr)
    else $error("mask bit not cleared");

  property p_rhr_read;
    bus.rd && bus.addr == OFF_RHR && s.rx_st != RX_STOP |=> !s.rx_ready;
  endproperty
  a_rhr_read: assert property (p_rhr_read)
    else $error("receive ready not cleared");

  property p_irq;
    1'b1 |=> irq == $past(irq_want);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");

  property p_no_tick;
    s.cd == 16'h0 |-> !tick;
  endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("tick with zero divisor");

  property p_local_idle;
    s.channel_mode == CHM_LOCAL |=> serial_tx_line;
  endproperty
  a_local_idle: assert property (p_local_idle)
    else $error("local loopback line not idle");

  property p_reserved;
    bus.rd && bus.addr > OFF_BAUD |=> rdata == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved read not zero");

  c_rx_char: cover property (s.rx_st == RX_STOP ##1 s.rx_ready);
  c_tx_char: cover property (s.tx_st == TX_STOP ##1 s.tx_st == TX_IDLE);
  c_overrun: cover property ($rose(s.overrun_flag));
  c_irq: cover property ($rose(irq));

endmodule

`default_nettype wire

// ---- rtl/uart_pkg.sv ----
package uart_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IER = 8'h08;
  localparam logic [7:0] OFF_IDR = 8'h0c;
  localparam logic [7:0] OFF_IMR = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_RHR = 8'h18;
  localparam logic [7:0] OFF_THR = 8'h1c;
  localparam logic [7:0] OFF_BAUD = 8'h20;

  // Control command bits
  localparam int CMD_RX_RESET = 2;
  localparam int CMD_TX_RESET = 3;
  localparam int CMD_RX_ENABLE = 4;
  localparam int CMD_RX_DISABLE = 5;
  localparam int CMD_TX_ENABLE = 6;
  localparam int CMD_TX_DISABLE = 7;
  localparam int CMD_STATUS_RESET = 8;

  // Mode fields
  localparam int PAR_LSB = 9;
  localparam int PAR_MSB = 11;
  localparam int CHM_LSB = 14;
  localparam int CHM_MSB = 15;
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_NONE = 3'h4;
  localparam logic [1:0] CHM_NORMAL = 2'h0;
  localparam logic [1:0] CHM_ECHO = 2'h1;
  localparam logic [1:0] CHM_LOCAL = 2'h2;
  localparam logic [1:0] CHM_REMOTE = 2'h3;

  // Status and mask bit positions
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_TX_EMPTY = 9;
  localparam logic [31:0] STAT_VALID = 32'h0000_02e3;

  // Bit timing in sampling ticks, and the last data bit index
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] START_MIN = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    tx_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rx_filt;
    logic [15:0] cd;
    logic [15:0] div_cnt;
    logic [2:0] parity_type;
    logic [1:0] channel_mode;
    logic [31:0] mask;
    logic rx_en;
    logic rx_pend;
    rx_state_t rx_st;
    logic [3:0] rx_tcnt;
    logic [2:0] rx_bcnt;
    logic [3:0] low_cnt;
    logic [7:0] rx_shift;
    logic rx_pe;
    logic [7:0] rx_character;
    logic rx_ready;
    logic overrun_flag;
    logic framing_flag;
    logic parity_error_flag;
    logic tx_en;
    logic tx_pend;
    tx_state_t tx_st;
    logic [3:0] tx_tcnt;
    logic [2:0] tx_bcnt;
    logic [7:0] tx_shift;
    logic tx_par;
    logic [7:0] tx_character;
    logic thr_full;
    logic [31:0] rdata;
    logic line;
    logic irq;
  } state_t;

endpackage

// ---- testbench/uart_remote_node.sv ----
`timescale 1ns/1ps
`default_nettype none

module uart_remote_node (
  // Clock
  input wire logic clock,
  // Serial lines
  output logic serial_rx_line,
  input wire logic serial_tx_line,
  // Captured character: {stop, parity, data}
  output logic got,
  output logic [9:0] got_frame
);
  int bit_clks = 16;
  logic [2:0] par_mode = 3'h0;

  initial begin
    serial_rx_line = 1'b1;
    got = 1'b0;
    got_frame = '0;
  end

  function automatic logic par_of(input logic [2:0] p, input logic [7:0] d);
    case (p)
      3'h0: par_of = ^d;
      3'h1: par_of = ~^d;
      3'h3: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  task automatic bit_out(input logic v);
    serial_rx_line <= v;
    repeat (bit_clks) @(posedge clock);
  endtask

  // ********************************************************
  // Sending side
  // ********************************************************
  task automatic send_char(input logic [7:0] d, input logic bad_par,
                           input logic bad_stop);
    @(posedge clock);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    if (par_mode != 3'h4) begin
      bit_out(par_of(par_mode, d) ^ bad_par);
    end
    // Short low stop so no false start follows it
    if (bad_stop) begin
      serial_rx_line <= 1'b0;
      repeat (bit_clks - 2) @(posedge clock);
    end
    bit_out(1'b1);
  endtask

  // ********************************************************
  // Receiving side
  // ********************************************************
  always begin : rx_side
    logic [9:0] f;
    @(negedge serial_tx_line);
    f = '0;
    repeat (bit_clks / 2) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      if (i != 8 || par_mode != 3'h4) begin
        repeat (bit_clks) @(posedge clock);
        f[i] = serial_tx_line;
      end
    end
    got_frame <= f;
    got <= 1'b1;
    @(posedge clock);
    got <= 1'b0;
  end
endmodule

`default_nettype wire

// ---- testbench/uart_register_interface_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module uart_register_interface_test
  import uart_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  bus_req_t bus = '0;
  logic [31:0] rdata;
  logic serial_rx_line;
  logic serial_tx_line;
  logic irq;
  logic got;
  logic [9:0] got_frame;
  logic rd_q = 1'b0;
  logic [31:0] exp_rd[$];
  logic [9:0] exp_ch[$];
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] v;
  logic [7:0] d;
  int p;
  logic [7:0] wo[6] = '{OFF_CTRL, OFF_IER, OFF_IDR, OFF_THR, 8'h3c, 8'hfc};

  always #5 clock = ~clock;

  uart_register_interface dut (.clock(clock), .arst_n(arst_n), .bus(bus),
    .rdata(rdata), .serial_rx_line(serial_rx_line),
    .serial_tx_line(serial_tx_line), .irq(irq));

  uart_remote_node remote (.clock(clock), .serial_rx_line(serial_rx_line),
    .serial_tx_line(serial_tx_line), .got(got), .got_frame(got_frame));

  // ********************************************************
  // Checking
  // ********************************************************
  task automatic fail(input string m);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) fail($sformatf("register got %h expected %h", g, e));
  endtask

  task automatic cmp_char(input logic [9:0] g);
    logic [9:0] e;
    n_tests++;
    if (exp_ch.size() == 0) begin
      fail($sformatf("unexpected character %h", g));
    end else begin
      e = exp_ch.pop_front();
      if (g !== e) fail($sformatf("character got %h expected %h", g, e));
    end
  endtask

  always @(posedge clock) begin
    if (rd_q) begin
      if (exp_rd.size() == 0) fail("read data without a note");
      else cmp_reg(rdata, exp_rd.pop_front());
    end
    if (got === 1'b1) cmp_char(got_frame);
    rd_q <= bus.rd;
  end

  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ********************************************************
  // Stimulus helpers
  // ********************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    exp_rd.push_back(e);
    @(posedge clock);
    bus <= '0;
  endtask

  function automatic logic [31:0] cmd_bit(input int b);
    cmd_bit = 32'h1 << b;
  endfunction

  function automatic logic [9:0] fr(input logic [7:0] x);
    fr = {1'b1, (remote.par_mode == 3'h4) ? 1'b0 :
          remote.par_of(remote.par_mode, x), x};
  endfunction

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clock);
    cmp_reg({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wait_tx();
    repeat (4000) begin
      if (exp_ch.size() == 0) break;
      @(posedge clock);
    end
    if (exp_ch.size() != 0) fail("character never arrived");
    repeat (remote.bit_clks) @(posedge clock);
  endtask

  task automatic mid_rx(input logic [7:0] x, input int cmd);
    fork
      remote.send_char(x, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge clock);
        wr(OFF_CTRL, cmd_bit(cmd));
      end
    join
  endtask

  initial begin
    #500us;
    fail("watchdog expired");
    summarize();
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    void'($urandom(32'h5e06937e));
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFF_MODE, 32'h0);
    rd(OFF_IMR, 32'h0);
    rd(OFF_RHR, 32'h0);
    rd(OFF_BAUD, 32'h0);
    rd(OFF_STAT, 32'h0);
    foreach (wo[i]) rd(wo[i], 32'h0);
    wr(OFF_IMR, $urandom);
    wr(OFF_STAT, $urandom);
    wr(OFF_RHR, $urandom);
    wr(8'h24, $urandom);
    rd(OFF_IMR, 32'h0);
    rd(OFF_RHR, 32'h0);
    rd(OFF_STAT, 32'h0);
    wr(OFF_IER, 32'hffff_ffff);
    rd(OFF_IMR, STAT_VALID);
    v = $urandom;
    wr(OFF_IDR, v);
    rd(OFF_IMR, STAT_VALID & ~v);
    wr(OFF_IER, v & 32'h3);
    rd(OFF_IMR, (STAT_VALID & ~v) | (v & 32'h3));
    wr(OFF_IDR, 32'hffff_ffff);
    rd(OFF_IMR, 32'h0);
    wr(OFF_BAUD, v);
    rd(OFF_BAUD, {16'h0, v[15:0]});
    wr(OFF_BAUD, 32'h1);
    wr(OFF_CTRL, cmd_bit(CMD_TX_ENABLE) | cmd_bit(CMD_TX_DISABLE));
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, cmd_bit(CMD_RX_ENABLE) | cmd_bit(CMD_RX_DISABLE) |
       cmd_bit(CMD_TX_ENABLE));
    remote.send_char(8'h5a, 1'b0, 1'b0);
    rd(OFF_STAT, 32'h202);
    wr(OFF_CTRL, cmd_bit(CMD_RX_ENABLE));
    rd(OFF_STAT, 32'h202);
    for (p = 0; p < 5; p++) begin
      wr(OFF_BAUD, 32'(p % 2 + 1));
      remote.bit_clks = 16 * (p % 2 + 1);
      remote.par_mode = 3'(p);
      wr(OFF_MODE, 32'(p) << PAR_LSB);
      rd(OFF_MODE, 32'(p) << PAR_LSB);
      d = $urandom;
      exp_ch.push_back(fr(d));
      wr(OFF_THR, {24'h0, d});
      d = $urandom;
      remote.send_char(d, 1'b0, 1'b0);
      wait_tx();
      rd(OFF_STAT, 32'h203);
      rd(OFF_RHR, {24'h0, d});
      rd(OFF_STAT, 32'h202);
    end
    wr(OFF_BAUD, 32'h1);
    remote.bit_clks = 16;
    remote.par_mode = 3'h0;
    wr(OFF_MODE, 32'h0);
    remote.send_char(8'h11, 1'b0, 1'b0);
    remote.send_char(8'h22, 1'b0, 1'b0);
    rd(OFF_STAT, 32'h223);
    rd(OFF_RHR, 32'h22);
    remote.send_char(8'h33, 1'b0, 1'b1);
    rd(OFF_STAT, 32'h263);
    rd(OFF_RHR, 32'h33);
    remote.send_char(8'h44, 1'b1, 1'b0);
    rd(OFF_STAT, 32'h2e3);
    wr(OFF_IER, 32'h20);
    chk_irq(1'b1);
    wr(OFF_CTRL, cmd_bit(CMD_STATUS_RESET));
    rd(OFF_STAT, 32'h203);
    chk_irq(1'b0);
    rd(OFF_RHR, 32'h44);
    wr(OFF_IDR, 32'h20);
    mid_rx(8'h3c, CMD_RX_DISABLE);
    rd(OFF_STAT, 32'h202);
    wr(OFF_CTRL, cmd_bit(CMD_RX_ENABLE));
    rd(OFF_STAT, 32'h203);
    rd(OFF_RHR, 32'h3c);
    mid_rx(8'hc3, CMD_RX_RESET);
    wr(OFF_CTRL, cmd_bit(CMD_RX_ENABLE));
    rd(OFF_STAT, 32'h202);
    exp_ch.push_back(fr(8'h81));
    exp_ch.push_back(fr(8'h7e));
    wr(OFF_THR, 32'h81);
    wr(OFF_THR, 32'h7e);
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, cmd_bit(CMD_TX_DISABLE));
    wait_tx();
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, cmd_bit(CMD_TX_ENABLE));
    rd(OFF_STAT, 32'h202);
    remote.par_mode = 3'h4;
    wr(OFF_MODE, 32'h4800);
    exp_ch.push_back(fr(8'ha5));
    remote.send_char(8'ha5, 1'b0, 1'b0);
    wait_tx();
    rd(OFF_RHR, 32'ha5);
    wr(OFF_MODE, 32'hc800);
    exp_ch.push_back(fr(8'h96));
    remote.send_char(8'h96, 1'b0, 1'b0);
    wait_tx();
    wr(OFF_MODE, 32'h8800);
    wr(OFF_THR, 32'h69);
    repeat (200) @(posedge clock);
    rd(OFF_STAT, 32'h203);
    rd(OFF_RHR, 32'h69);
    wr(OFF_MODE, 32'h0);
    repeat (20) @(posedge clock);
    summarize();
  end
endmodule

`default_nettype wire
